/* File: hw/dlp_ctrl_regs.sv */
// Global and channel-0 control register bank of a two-channel line unit.
// Assumes alarm inputs and line data are synchronous to clk and that
// bit_tick pulses once per line bit period.
`default_nettype none
// Overview of operation
// R1: Receiver enable bits 4 and 5 at 0x00.
// R2: Transmitter drives only when bit and pin high.
// R3: Global per-channel interrupt gate at 0x20.
// R4: Read-only per-channel pending status at 0x21.
// R5: Read-only part identifier at 0x3E.
// R6: Read-only silicon revision at 0x3F.
// R7: Channel-0 source enables, drive monitor and LOS.
// R8: Channel-0 causes at 0x02, cleared on read.
// R9: Live channel-0 alarms read-only at 0x03.
// R10: Channel-0 transmit settings at 0x04.
// R11: Channel-0 receive settings at 0x05.
// R12: Channel-0 block settings; 0x07, 0x08 reserved.
// R13: Drive alarm after 128 pulseless bit periods.
// R14: Cause set on alarm change, read clears.
// R15: Active-low interrupt output to host.
// R16: Mute recovered data on loss when enabled.
module dlp_ctrl_regs #(
  parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] REVISION = 8'h01 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic irq_n,
  input wire logic [1:0] transmitter_on_pin,
  output logic [1:0] tx_drive_en,
  output logic [1:0] rx_enable,
  input wire logic ch1_irq_req,
  input wire logic bit_tick,
  input wire logic mon_pulse,
  input wire logic rx_signal_loss_alarm,
  input wire logic rx_lock_loss_alarm,
  input wire logic analog_loss_alarm,
  input wire logic digital_loss_alarm,
  input wire logic prbs_lock_state,
  input wire logic rpos_in,
  input wire logic rneg_in,
  output logic rpos_out,
  output logic rneg_out,
  output logic [5:0] tx_settings,
  output logic [5:0] rx_settings,
  output logic [5:0] block_settings
);
  logic rd_stb, wr_stb;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;

  dlp_serial_port u_port (
    .clk(clk),
    .rst(rst),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .rd_stb(rd_stb),
    .wr_stb(wr_stb),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata)
  );

  logic [7:0] redund_q, redund_d;
  logic [1:0] ch_en_q, ch_en_d;
  logic [2:0] cause_q, cause_d;
  logic [1:0] gate_q, gate_d;
  logic [5:0] tx_q, tx_d;
  logic [5:0] rx_q, rx_d;
  logic [5:0] blk_q, blk_d;
  logic [7:0] gap_q, gap_d;
  logic dmo_q, dmo_d;
  logic [2:0] prev_q, prev_d;
  logic rpos_q, rpos_d, rneg_q, rneg_d;
  logic irq_n_q, irq_n_d;
  logic [2:0] live;
  logic [7:0] alarm_word;
  logic [1:0] pending;

  // Drive monitor alarm: counting only while the monitor is enabled keeps
  // the alarm quiet on channels that leave the monitor pins unconnected.
  always_comb begin
    gap_d = gap_q;
    dmo_d = dmo_q;
    if (!tx_q[dlp_pkg::POS_TX_DMON_EN]) begin
      gap_d = 8'h00;
      dmo_d = 1'b0;
    end else if (mon_pulse) begin
      gap_d = 8'h00;
      dmo_d = 1'b0;
    end else if (bit_tick && gap_q < dlp_pkg::DMO_LIMIT) begin
      gap_d = gap_q + 8'h01;
      if (gap_q + 8'h01 == dlp_pkg::DMO_LIMIT) begin
        dmo_d = 1'b1; // R13
      end
    end
  end

  assign live = {rx_lock_loss_alarm, rx_signal_loss_alarm, dmo_q};

  always_comb begin
    alarm_word = 8'h00;
    alarm_word[dlp_pkg::POS_DMO] = dmo_q; // R9
    alarm_word[dlp_pkg::POS_LOS] = rx_signal_loss_alarm;
    alarm_word[dlp_pkg::POS_LOL] = rx_lock_loss_alarm;
    alarm_word[dlp_pkg::POS_ALOS] = analog_loss_alarm;
    alarm_word[dlp_pkg::POS_DLOS] = digital_loss_alarm;
    alarm_word[dlp_pkg::POS_PRBS] = prbs_lock_state;
  end

  // Pending per channel; loss of lock has no source enable so it only
  // shows in the cause register and never raises the interrupt.
  assign pending[0] = gate_q[0] & |(cause_q[1:0] & ch_en_q); // R4 R7
  assign pending[1] = gate_q[1] & ch1_irq_req; // R3

  // Register writes and read-clear of the cause register.
  always_comb begin
    redund_d = redund_q;
    ch_en_d = ch_en_q;
    gate_d = gate_q;
    tx_d = tx_q;
    rx_d = rx_q;
    blk_d = blk_q;
    cause_d = cause_q;
    prev_d = live;
    if (wr_stb) begin
      case (addr)
        dlp_pkg::OFS_REDUNDANCY: redund_d = wdata & 8'h33; // R1
        dlp_pkg::OFS_CH0_IRQ_EN: ch_en_d = wdata[1:0]; // R7
        dlp_pkg::OFS_CH0_TX: tx_d = wdata[5:0] & 6'h37; // R10
        dlp_pkg::OFS_CH0_RX: rx_d = wdata[5:0]; // R11
        dlp_pkg::OFS_CH0_BLOCK: blk_d = wdata[5:0]; // R12
        dlp_pkg::OFS_GLB_IRQ_EN: gate_d = wdata[1:0]; // R3
        default: ; // R5 R6
      endcase
    end
    if (rd_stb && addr == dlp_pkg::OFS_CH0_CAUSE) begin
      cause_d = 3'b000; // R8
    end
    // A change in the clearing cycle still sets its bit.
    cause_d = cause_d | (live ^ prev_q); // R14
  end

  // Read mux; reserved and unmapped offsets read as zero.
  always_comb begin
    case (addr)
      dlp_pkg::OFS_REDUNDANCY: rdata = redund_q;
      dlp_pkg::OFS_CH0_IRQ_EN: rdata = {6'h00, ch_en_q};
      dlp_pkg::OFS_CH0_CAUSE: rdata = {5'h00, cause_q}; // R8
      dlp_pkg::OFS_CH0_ALARM: rdata = alarm_word;
      dlp_pkg::OFS_CH0_TX: rdata = {2'b00, tx_q};
      dlp_pkg::OFS_CH0_RX: rdata = {2'b00, rx_q};
      dlp_pkg::OFS_CH0_BLOCK: rdata = {2'b00, blk_q};
      dlp_pkg::OFS_GLB_IRQ_EN: rdata = {6'h00, gate_q};
      dlp_pkg::OFS_GLB_PENDING: rdata = {6'h00, pending}; // R4
      dlp_pkg::OFS_PART_ID: rdata = PART_ID; // R5
      dlp_pkg::OFS_REVISION: rdata = REVISION; // R6
      default: rdata = 8'h00;
    endcase
  end

  // Line-side outputs.
  always_comb begin
    irq_n_d = ~|pending; // R15
    rpos_d = rpos_in;
    rneg_d = rneg_in;
    if (rx_q[dlp_pkg::POS_RX_MUTE] && rx_signal_loss_alarm) begin
      rpos_d = 1'b0; // R16
      rneg_d = 1'b0;
    end
  end

  assign tx_drive_en = redund_q[dlp_pkg::POS_TX_ON +: 2] & transmitter_on_pin; // R2
  assign rx_enable = redund_q[dlp_pkg::POS_RX_ON +: 2]; // R1
  assign tx_settings = tx_q;
  assign rx_settings = rx_q;
  assign block_settings = blk_q;
  assign irq_n = irq_n_q;
  assign rpos_out = rpos_q;
  assign rneg_out = rneg_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      redund_q <= dlp_pkg::RST_REG;
      ch_en_q <= 2'b00;
      gate_q <= 2'b00;
      tx_q <= 6'h00;
      rx_q <= 6'h00;
      blk_q <= 6'h00;
      cause_q <= 3'b000;
      prev_q <= 3'b000;
      gap_q <= 8'h00;
      dmo_q <= 1'b0;
      irq_n_q <= 1'b1;
      rpos_q <= 1'b0;
      rneg_q <= 1'b0;
    end else begin
      redund_q <= redund_d;
      ch_en_q <= ch_en_d;
      gate_q <= gate_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      blk_q <= blk_d;
      cause_q <= cause_d;
      prev_q <= prev_d;
      gap_q <= gap_d;
      dmo_q <= dmo_d;
      irq_n_q <= irq_n_d;
      rpos_q <= rpos_d;
      rneg_q <= rneg_d;
    end
  end
endmodule // dlp_ctrl_regs
`default_nettype wire

/* File: hw/dlp_pkg.sv */
// Package of shared constants for the dual line port control register bank.
// Assumes an 8-bit register space reached through the serial host port.
`default_nettype none
package dlp_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [5:0] OFS_REDUNDANCY = 6'h00;
  localparam logic [5:0] OFS_CH0_IRQ_EN = 6'h01;
  localparam logic [5:0] OFS_CH0_CAUSE = 6'h02;
  localparam logic [5:0] OFS_CH0_ALARM = 6'h03;
  localparam logic [5:0] OFS_CH0_TX = 6'h04;
  localparam logic [5:0] OFS_CH0_RX = 6'h05;
  localparam logic [5:0] OFS_CH0_BLOCK = 6'h06;
  localparam logic [5:0] OFS_GLB_IRQ_EN = 6'h20;
  localparam logic [5:0] OFS_GLB_PENDING = 6'h21;
  localparam logic [5:0] OFS_PART_ID = 6'h3E;
  localparam logic [5:0] OFS_REVISION = 6'h3F;

  // Field positions in the redundancy register.
  localparam int unsigned POS_TX_ON = 0;
  localparam int unsigned POS_RX_ON = 4;

  // Alarm and cause bit positions.
  localparam int unsigned POS_DMO = 0;
  localparam int unsigned POS_LOS = 1;
  localparam int unsigned POS_LOL = 2;
  localparam int unsigned POS_ALOS = 4;
  localparam int unsigned POS_DLOS = 5;
  localparam int unsigned POS_PRBS = 6;

  // Control field positions.
  localparam int unsigned POS_TX_DMON_EN = 5;
  localparam int unsigned POS_RX_MUTE = 2;

  // Values after reset.
  localparam logic [7:0] RST_REG = 8'h00;

  // Drive monitor: bit periods without a pulse before the alarm.
  localparam int unsigned DMO_BITS = 128;
  localparam logic [7:0] DMO_LIMIT = 8'h80;

  // Serial frame layout: bit counts.
  localparam logic [4:0] SER_HDR_BITS = 5'h08;
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;
endpackage : dlp_pkg
`default_nettype wire

/* File: hw/dlp_serial_port.sv */
// Serial host port front end: turns chip select, serial clock and data
// into register read and write strobes. Pins are synchronous to clk.
`default_nettype none
module dlp_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic rd_stb,
  output logic wr_stb,
  output logic [5:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  logic sclk_q, sclk_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] in_q, in_d;
  logic [7:0] out_q, out_d;
  logic wr_pend_q, wr_pend_d;
  logic rise;

  assign rise = sclk & ~sclk_q & ~cs_n;
  // Frame: bit 0 read flag, bits 1..6 address LSB first, bit 7 unused,
  // bits 8..15 data LSB first.
  // A read decodes its address while the header still sits at the top of
  // the shifter; a write waits one cycle so address and data are in place.
  assign addr = wr_stb ? in_q[6:1] : in_q[15:10];
  assign wdata = in_q[15:8];
  assign sdo = out_q[0];

  always_comb begin
    sclk_d = sclk;
    cnt_d = cnt_q;
    in_d = in_q;
    out_d = out_q;
    rd_stb = 1'b0;
    wr_stb = wr_pend_q;
    wr_pend_d = 1'b0;
    if (cs_n) begin
      cnt_d = 5'h00;
    end else if (rise && cnt_q < dlp_pkg::SER_FRAME_BITS) begin
      in_d = {sdi, in_q[15:1]};
      cnt_d = cnt_q + 5'h01;
      if (cnt_q >= dlp_pkg::SER_HDR_BITS) begin
        out_d = {1'b0, out_q[7:1]};
      end
    end
    // Header completes on this rise: a read takes its data and clears
    // sticky bits.
    if (cnt_d == dlp_pkg::SER_HDR_BITS && cnt_q != cnt_d && in_q[9]) begin
      rd_stb = 1'b1;
    end
    if (cnt_d == dlp_pkg::SER_FRAME_BITS && cnt_q != cnt_d && !in_q[1]) begin
      wr_pend_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cnt_q <= 5'h00;
      in_q <= 16'h0000;
      out_q <= 8'h00;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      in_q <= in_d;
      out_q <= rd_stb ? rdata : out_d;
    end
  end
endmodule // dlp_serial_port
`default_nettype wire

/* File: verif/dlp_ctrl_regs_checker.sv */
// Port checker for the control register bank, attached by bind.
// Assumes the synchronous active-high reset of the bank.
`default_nettype none
module dlp_ctrl_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic [1:0] transmitter_on_pin,
  input wire logic [1:0] tx_drive_en,
  input wire logic [1:0] rx_enable,
  input wire logic rx_signal_loss_alarm,
  input wire logic rpos_in,
  input wire logic rpos_out,
  input wire logic rneg_out,
  input wire logic [5:0] tx_settings,
  input wire logic [5:0] rx_settings,
  input wire logic [5:0] block_settings
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_tx_gate;
    (tx_drive_en & ~transmitter_on_pin) == 2'b00;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("drive w/o pin");
  property p_tx_cause;
    $changed(tx_drive_en) |-> $changed(transmitter_on_pin) || !$past(cs_n);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("drive moved");
  property p_rx_en;
    $changed(rx_enable) |-> !$past(cs_n);
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("rx enable moved");
  property p_tx_set;
    $changed(tx_settings) |-> !$past(cs_n);
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx moved");
  property p_tx_rsvd;
    tx_settings[3] == 1'b0;
  endproperty
  a_tx_rsvd: assert property (p_tx_rsvd) else $error("tx bit3 set");
  property p_rx_set;
    $changed(rx_settings) |-> !$past(cs_n);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx moved");
  property p_blk_set;
    $changed(block_settings) |-> !$past(cs_n);
  endproperty
  a_blk_set: assert property (p_blk_set) else $error("blk moved");
  property p_mute;
    rx_settings[2] && rx_signal_loss_alarm |=> !rpos_out && !rneg_out;
  endproperty
  a_mute: assert property (p_mute) else $error("data not muted");
  property p_pass;
    !(rx_settings[2] && rx_signal_loss_alarm) |=> rpos_out == $past(rpos_in);
  endproperty
  a_pass: assert property (p_pass) else $error("data not passed");
endmodule // dlp_ctrl_regs_checker
bind dlp_ctrl_regs dlp_ctrl_regs_checker dlp_ctrl_regs_checker_i (.clk,
  .rst, .cs_n, .transmitter_on_pin, .tx_drive_en, .rx_enable,
  .rx_signal_loss_alarm, .rpos_in, .rpos_out, .rneg_out, .tx_settings,
  .rx_settings, .block_settings);
`default_nettype wire

/* File: verif/dlp_host_model.sv */
// Host processor model: sends serial frames to the register bank.
// Assumes clk is the bank's clock; the bench calls frame() by path.
`default_nettype none
module dlp_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Each serial clock phase lasts two cycles, twice the shortest the port takes.
  task automatic frame(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi = f[i];
      sclk = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      if (i > 7) rd[i-8] = sdo;
      sclk = 1'b1;
      repeat (2) @(posedge clk);
      #1;
    end
    sclk = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cs_n = 1'b1;
    // An idle data line must not hold a value the port could trust.
    sdi = ~sdi;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule // dlp_host_model
`default_nettype wire

/* File: verif/test_dlp_ctrl_regs.sv */
// Bench for the control register bank: serial host traffic and line pins.
// Assumes the host model owns the serial port; alarms are driven here.
`default_nettype none
module test_dlp_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID = 8'hC3; // Arbitrary value.
  localparam logic [7:0] REV = 8'h27; // Arbitrary value.
  logic clk, rst, cs_n, sclk, sdi, sdo, irq_n, ch1, tick, mon;
  logic los, lol, alos, dlos, prbs, rp, rn, rpo, rno;
  logic [1:0] pin, txe, rxe;
  logic [5:0] txs, rxs, bks;
  int n_checks = 0;
  int bad_count = 0;
  logic [5:0] ra [14] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h07, 6'h08, 6'h20, 6'h21, 6'h2A, 6'h3E, 6'h3F};
  logic [7:0] rm [14] = '{8'h33, 8'h03, 8'h00, 8'h00, 8'h37, 8'h3F,
    8'h3F, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, ID, REV};
  dlp_ctrl_regs #(.PART_ID(ID), .REVISION(REV)) dlp_ctrl_regs_i (.clk,
    .rst, .cs_n, .sclk, .sdi, .sdo, .irq_n, .transmitter_on_pin(pin),
    .tx_drive_en(txe), .rx_enable(rxe), .ch1_irq_req(ch1),
    .bit_tick(tick), .mon_pulse(mon), .rx_signal_loss_alarm(los),
    .rx_lock_loss_alarm(lol), .analog_loss_alarm(alos),
    .digital_loss_alarm(dlos), .prbs_lock_state(prbs), .rpos_in(rp),
    .rneg_in(rn), .rpos_out(rpo), .rneg_out(rno), .tx_settings(txs),
    .rx_settings(rxs), .block_settings(bks));
  dlp_host_model dlp_host_model_i (.clk, .cs_n, .sclk, .sdi, .sdo);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    dlp_host_model_i.frame({d, 1'b0, a, 1'b0}, r);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    dlp_host_model_i.frame({8'h00, 1'b0, a, 1'b1}, r);
    chk(r, e);
  endtask
  // A lost interrupt must end the run rather than hang it.
  task automatic wait_irq(input logic v);
    for (int k = 0; k < 8 && irq_n !== v; k++) step(1);
    chk({7'h00, irq_n}, {7'h00, v});
    if (irq_n !== v) test_done;
  endtask
  initial begin
    rst = 1'b1;
    {pin, ch1, tick, mon, los, lol, alos, dlos, prbs, rp, rn} = '0;
    step(6);
    rst = 1'b0;
    chk({6'h00, txe}, 8'h00);
    for (int i = 0; i < 14; i++) rd_chk(ra[i], i > 11 ? rm[i] : 8'h00);
    for (int i = 0; i < 14; i++) begin
      wr(ra[i], 8'hFF);
      rd_chk(ra[i], rm[i]);
    end
    chk({2'b00, txs}, 8'h37);
    chk({2'b00, rxs}, 8'h3F);
    chk({2'b00, bks}, 8'h3F);
    chk({6'h00, rxe}, 8'h03);
    for (int p = 0; p < 4; p++) begin
      pin = p[1:0];
      #1 chk({6'h00, txe}, {6'h00, p[1:0]});
    end
    wr(6'h00, 8'h00);
    chk({6'h00, txe}, 8'h00);
    chk({6'h00, rxe}, 8'h00);
    $display("test registers done");
    {los, lol, alos, dlos, prbs} = '1;
    step(3);
    rd_chk(6'h03, 8'h76);
    rd_chk(6'h02, 8'h06);
    rd_chk(6'h02, 8'h00);
    wr(6'h01, 8'h02);
    wr(6'h20, 8'h01);
    los = 1'b0;
    wait_irq(1'b0);
    rd_chk(6'h21, 8'h01);
    rd_chk(6'h02, 8'h02);
    wait_irq(1'b1);
    rd_chk(6'h21, 8'h00);
    wr(6'h20, 8'h00);
    los = 1'b1;
    step(4);
    chk({7'h00, irq_n}, 8'h01);
    wr(6'h20, 8'h01);
    wait_irq(1'b0);
    rd_chk(6'h02, 8'h02);
    ch1 = 1'b1;
    step(4);
    chk({7'h00, irq_n}, 8'h01);
    wr(6'h20, 8'h02);
    wait_irq(1'b0);
    ch1 = 1'b0;
    wait_irq(1'b1);
    $display("test interrupts done");
    wr(6'h05, 8'h04);
    {rp, rn} = 2'b11;
    step(2);
    chk({6'h00, rpo, rno}, 8'h00);
    los = 1'b0;
    step(2);
    chk({6'h00, rpo, rno}, 8'h03);
    $display("test mute done");
    {lol, alos, dlos, prbs} = '0;
    wr(6'h04, 8'h20);
    for (int t = 0; t < 128; t++) begin
      if (t == 127) rd_chk(6'h03, 8'h00);
      tick = 1'b1;
      step(1);
      tick = 1'b0;
      step(1);
    end
    rd_chk(6'h03, 8'h01);
    mon = 1'b1;
    step(1);
    mon = 1'b0;
    rd_chk(6'h03, 8'h00);
    $display("test drive monitor done");
    test_done;
  end
endmodule // test_dlp_ctrl_regs
`default_nettype wire
